// ==== pkg/cmp2_ctrl_map.vh ====
// Register map constants for the second comparator control/status block
// Assumes inclusion by bare name from design files
`ifndef CMP2_CTRL_MAP_VH
`define CMP2_CTRL_MAP_VH
`define CSR_ADDR            4'h0
`define CSR_RESET           32'h0000_0000
`define CSR_RD_MASK_UNUSED  32'h0000_0000
`define F_MODE_LO           18
`define F_MODE_HI           19
`define F_MINUS_LO          20
`define F_MINUS_HI          22
`define F_WINDOW            23
`define F_ROUTE_LO          24
`define F_ROUTE_HI          26
`define F_POL               27
`define F_HYST_LO           28
`define F_HYST_HI           29
`define F_OUT               30
`define F_LOCK              31
`define MINUS_RESERVED      3'h7
`define ROUTE_NONE          3'h0
`define ROUTE_T1_IRQ        3'h1
`define ROUTE_T1_CAP1       3'h2
`define ROUTE_T1_RCLR       3'h3
`define ROUTE_T2_CAP4       3'h4
`define ROUTE_T2_RCLR       3'h5
`define ROUTE_T3_CAP1       3'h6
`define ROUTE_T3_RCLR       3'h7
`endif

// ==== verilog/cmp2_sync.v ====
// Two-flop synchroniser for the analog comparator result
// Assumes an asynchronous level input and a single system clock
`timescale 1ns/1ps
module cmp2_sync (
    // Clock and reset
    input  wire i_clk,
    input  wire i_resetn,
    // Asynchronous level in, synchronised level out
    input  wire i_async,
    output reg  o_sync
);
    reg meta_q;

    // First flop only feeds the second
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // cmp2_sync

// ==== verilog/cmp2_route.v ====
// Output router: steers the comparator result to one timer input
// Assumes route code from the control register and a registered result
`timescale 1ns/1ps
`include "cmp2_ctrl_map.vh"
module cmp2_route (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_resetn,
    // Route code and result
    input  wire [2:0] i_route,
    input  wire       i_value,
    // Timer inputs, one hot by route code
    output reg  [6:0] o_timer
);
    integer k;

    // Bit k carries the result when route code is k+1
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_timer <= 7'h00;
        end else begin
            for (k = 0; k < 7; k = k + 1) begin
                o_timer[k] <= i_value && (i_route == (k[2:0] + 3'h1));
            end
        end
    end
endmodule // cmp2_route

// ==== verilog/cmp2_ctrl.v ====
// Second comparator control/status register bank on Avalon-MM
// Assumes one clock, analog result level from the comparator macro
`timescale 1ns/1ps
`include "cmp2_ctrl_map.vh"
module cmp2_ctrl (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_resetn,
    // Avalon-MM slave
    input  wire [3:0]  i_address,
    input  wire        i_read,
    input  wire        i_write,
    input  wire [31:0] i_writedata,
    input  wire [3:0]  i_byteenable,
    output reg  [31:0] o_readdata,
    output reg         o_waitrequest,
    // Analog comparator raw result (non-inverting above inverting)
    input  wire        i_cmp_raw,
    // Analog controls
    output reg  [1:0]  o_power_mode,
    output reg  [3:0]  o_speed_onehot,
    output reg  [2:0]  o_minus_select,
    output reg         o_minus_is_pin,
    output reg         o_window_couple,
    output reg  [1:0]  o_hysteresis,
    output reg         o_locked,
    // Timer inputs
    output wire [6:0]  o_timer_in
);
    // Stored control fields
    reg  [1:0] mode_q;
    reg  [2:0] minus_q;
    reg        win_q;
    reg  [2:0] route_q;
    reg        pol_q;
    reg  [1:0] hyst_q;
    reg        lock_q;
    reg        out_q;
    reg        ack_q;
    wire       cmp_sync;
    wire       hit;
    wire       rd_go;
    wire [31:0] csr_view;

    // One-hot speed decode, used by output stage
    function [3:0] mode_dec;
        input [1:0] m;
        begin
            mode_dec = 4'h1 << m;
        end
    endfunction

    cmp2_sync u_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_cmp_raw),
        .o_sync   (cmp_sync)
    );

    cmp2_route u_route (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_route  (route_q),
        .i_value  (out_q),
        .o_timer  (o_timer_in)
    );

    // Bus decode; answer one cycle after the request
    assign hit   = (i_address == `CSR_ADDR);
    assign rd_go = i_read && !ack_q;

    // Waitrequest drops for the cycle after a request is seen
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (i_read || i_write) && !ack_q;
        end
    end

    always @* begin
        o_waitrequest = !ack_q;
    end

    // Control field writes, gated by lock and byte lanes
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_q  <= 2'h0;
            minus_q <= 3'h0;
            win_q   <= 1'b0;
            route_q <= 3'h0;
            pol_q   <= 1'b0;
            hyst_q  <= 2'h0;
            lock_q  <= 1'b0;
        end else if (i_write && ack_q && hit && !lock_q) begin
            if (i_byteenable[2]) begin
                mode_q  <= i_writedata[`F_MODE_HI:`F_MODE_LO];
                minus_q <= i_writedata[`F_MINUS_HI:`F_MINUS_LO];
                win_q   <= i_writedata[`F_WINDOW];
            end
            if (i_byteenable[3]) begin
                route_q <= i_writedata[`F_ROUTE_HI:`F_ROUTE_LO];
                pol_q   <= i_writedata[`F_POL];
                hyst_q  <= i_writedata[`F_HYST_HI:`F_HYST_LO];
                lock_q  <= i_writedata[`F_LOCK];
            end
        end
    end

    // Polarity-applied, synchronised output state
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            out_q <= 1'b0;
        end else begin
            out_q <= cmp_sync ^ pol_q;
        end
    end

    // Register view; other bits read zero
    assign csr_view = {lock_q, out_q, hyst_q, pol_q, route_q, win_q, minus_q, mode_q,
                       18'h00000};

    // Read data, registered at the answer
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            o_readdata <= hit ? csr_view : 32'h0000_0000;
        end
    end

    // Analog control outputs, all registered
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_power_mode    <= 2'h0;
            o_speed_onehot  <= 4'h1;
            o_minus_select  <= 3'h0;
            o_minus_is_pin  <= 1'b0;
            o_window_couple <= 1'b0;
            o_hysteresis    <= 2'h0;
            o_locked        <= 1'b0;
        end else begin
            o_power_mode    <= mode_q;
            o_speed_onehot  <= mode_dec(mode_q);
            o_minus_select  <= (minus_q == `MINUS_RESERVED) ? 3'h0 : minus_q;
            o_minus_is_pin  <= minus_q[2] && (minus_q != `MINUS_RESERVED);
            o_window_couple <= win_q;
            o_hysteresis    <= hyst_q;
            o_locked        <= lock_q;
        end
    end
endmodule // cmp2_ctrl

// ==== sim/cmp2_ctrl_monitor.sv ====
// Checker on the comparator control bank ports
// Assumes bind onto cmp2_ctrl, one clock
`timescale 1ns/1ps
module cmp2_ctrl_monitor (
    // Clock, reset, bus
    input wire        i_clk, i_resetn, i_read, i_write, o_waitrequest,
    input wire [3:0]  i_address, i_byteenable,
    input wire [31:0] i_writedata, o_readdata,
    // Analog controls and timers
    input wire        o_minus_is_pin, o_window_couple, o_locked,
    input wire [1:0]  o_power_mode, o_hysteresis,
    input wire [3:0]  o_speed_onehot,
    input wire [2:0]  o_minus_select,
    input wire [6:0]  o_timer_in
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Accepted unlocked write to the control word
    wire wr_ok = i_write && !o_waitrequest && i_address == 4'h0 && !o_locked;
    chk_mode_write: assert property (wr_ok && i_byteenable[2] |-> ##2
        o_power_mode == $past(i_writedata[19:18], 2)) else $error("mode bad");
    chk_window_write: assert property (wr_ok && i_byteenable[2] |-> ##2
        o_window_couple == $past(i_writedata[23], 2)) else $error("window bad");
    chk_hyst_write: assert property (wr_ok && i_byteenable[3] |-> ##2
        o_hysteresis == $past(i_writedata[29:28], 2)) else $error("hyst bad");
    chk_speed_code: assert property (o_speed_onehot == 4'h1 << o_power_mode)
        else $error("speed bad");
    chk_minus_pin: assert property (o_minus_is_pin == o_minus_select[2]
        && o_minus_select != 3'h7) else $error("minus bad");
    chk_lock_keep: assert property (o_locked |=> o_locked) else $error("unlock");
    chk_lock_freeze: assert property (o_locked |=> $stable({o_power_mode,
        o_minus_select, o_window_couple, o_hysteresis})) else $error("locked change");
    chk_route_one: assert property ($onehot0(o_timer_in)) else $error("route bad");
    chk_low_zero: assert property (i_read && !o_waitrequest |->
        o_readdata[17:0] == 18'h0) else $error("low bits");
    cover property (wr_ok);
    cover property ($rose(o_locked));
    cover property (|o_timer_in);
endmodule // cmp2_ctrl_monitor

// ==== sim/timer_inputs_model.sv ====
// Timer side: latches the last driven timer input pattern
// Assumes the timer inputs of cmp2_ctrl, one clock
`timescale 1ns/1ps
module timer_inputs_model (
    input  wire       i_clk,
    input  wire       i_resetn,
    input  wire [6:0] i_timer,
    output reg  [6:0] o_last
);
    // Keep the last non-idle input
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn)
            o_last <= 7'h00;
        else if (|i_timer)
            o_last <= i_timer;
    end
endmodule // timer_inputs_model

// ==== sim/cmp2_ctrl_tb.sv ====
// Bench: random field writes, readback, routing, lock
// Assumes cmp2_ctrl, timer model and monitor
`timescale 1ns/1ps
module cmp2_ctrl_tb;
    reg         i_clk = 1'b0, i_resetn = 1'b0, i_read = 1'b0, i_write = 1'b0, i_cmp_raw = 1'b0;
    reg  [3:0]  i_address = 4'h0, i_byteenable = 4'hf;
    reg  [31:0] i_writedata = 32'h0, rd, w;
    wire [31:0] o_readdata;
    wire        o_waitrequest, o_minus_is_pin, o_window_couple, o_locked;
    wire [1:0]  o_power_mode, o_hysteresis;
    wire [3:0]  o_speed_onehot;
    wire [2:0]  o_minus_select;
    wire [6:0]  o_timer_in, last;
    integer     seed = 91290, fails = 0, checked = 0, i, n;
    always #5 i_clk = ~i_clk;
    cmp2_ctrl u_dut (.*);
    timer_inputs_model u_timers (.i_clk(i_clk), .i_resetn(i_resetn), .i_timer(o_timer_in),
        .o_last(last));
    // Expected readback and timer pattern
    function [31:0] exp_rd(input [31:0] v, input raw);
        exp_rd = (v & 32'hbffc_0000) | {1'b0, raw ^ v[27], 30'h0};
    endfunction
    function [6:0] exp_tm(input [31:0] v, input raw);
        exp_tm = (raw ^ v[27]) && v[26:24] != 3'h0 ? 7'h01 << (v[26:24] - 3'h1) : 7'h00;
    endfunction
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("[FAIL] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task summarize;
        begin
            if (fails == 0 && checked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // One bus access, held until waitrequest is sampled low
    task bus(input wr, input [3:0] a, input [31:0] d);
        begin
            i_read <= !wr;
            i_write <= wr;
            i_address <= a;
            i_writedata <= d;
            n = 0;
            @(posedge i_clk);
            while (o_waitrequest && n < 20) begin
                n = n + 1;
                @(posedge i_clk);
            end
            rd = o_readdata;
            i_read <= 1'b0;
            i_write <= 1'b0;
            @(posedge i_clk);
            if (n == 20) begin
                fails = fails + 1;
                summarize;
            end
        end
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        bus(0, 4'h0, 0);
        cmp(rd, 0);
        for (i = 0; i < 12; i = i + 1) begin
            w = $random(seed);
            i_cmp_raw <= w[0];
            w = w & 32'h3ffc_0000;
            if (i < 8)
                w[29:18] = {i[1:0], 1'b0, i[2:0], 1'b0, 3'h7 ^ i[2:0], i[1:0]};
            bus(1, 4'h0, w);
            repeat (4) @(posedge i_clk);
            bus(0, 4'h0, 0);
            cmp(rd, exp_rd(w, i_cmp_raw));
            cmp(o_timer_in, exp_tm(w, i_cmp_raw));
            if (|exp_tm(w, i_cmp_raw))
                cmp(last, exp_tm(w, i_cmp_raw));
            cmp({o_power_mode, o_minus_select, o_window_couple, o_hysteresis}, {w[19:18],
                w[22:20] == 3'h7 ? 3'h0 : w[22:20], w[23], w[29:28]});
            cmp({o_locked, o_minus_is_pin, o_speed_onehot}, {1'b0, w[22] && w[22:20] != 3'h7,
                4'h1 << w[19:18]});
        end
        bus(1, 4'h5, 32'hffff_ffff);
        bus(0, 4'h5, 0);
        cmp(rd, 0);
        w = 32'h9234_0000;
        bus(1, 4'h0, w);
        bus(1, 4'h0, 32'h2dc8_0000);
        repeat (4) @(posedge i_clk);
        bus(0, 4'h0, 0);
        cmp(rd, exp_rd(w, i_cmp_raw));
        cmp(o_locked, 1);
        i_cmp_raw <= 1'b0;
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_clk);
        bus(0, 4'h0, 0);
        cmp(rd, 0);
        summarize;
    end
endmodule // cmp2_ctrl_tb
bind cmp2_ctrl cmp2_ctrl_monitor u_mon (.*);
